// ==== include/asp_pkg.sv ====
// Shared constants and types for both ends of the serial port link
package asp_pkg;

  // Device control and data locations
  localparam logic [7:0] ADDR_CTRL   = 8'h98;
  localparam logic [7:0] ADDR_DATA   = 8'h99;
  localparam logic [7:0] CTRL_RESET  = 8'h40;
  localparam logic [7:0] UNUSED_MASK = 8'h40;
  localparam logic [7:0] DATA_RESET  = 8'h00;

  // Control field positions
  localparam int BIT_MODE  = 7;
  localparam int BIT_CHECK = 5;
  localparam int BIT_REN   = 4;
  localparam int BIT_TB8   = 3;
  localparam int BIT_RB8   = 2;
  localparam int BIT_TI    = 1;
  localparam int BIT_RI    = 0;

  // Frame lengths in bit times, and index of the last receive sample
  localparam logic [3:0] FRAME8_BITS = 4'hA;
  localparam logic [3:0] FRAME9_BITS = 4'hB;
  localparam logic [3:0] LAST8_IDX   = 4'h9;
  localparam logic [3:0] LAST9_IDX   = 4'hA;
  localparam logic [7:0] TIMER_TOP   = 8'hFF;

  // Remote end registers, byte addresses on APB
  localparam logic [7:0] RMT_CTRL    = 8'h00;
  localparam logic [7:0] RMT_DIV     = 8'h04;
  localparam logic [7:0] RMT_TXDATA  = 8'h08;
  localparam logic [7:0] RMT_RXDATA  = 8'h0C;
  localparam logic [7:0] RMT_STATUS  = 8'h10;
  localparam logic [15:0] RMT_DIV_RESET = 16'h0010;

  typedef enum logic [0:0] {
    RX_IDLE = 1'b0,
    RX_BITS = 1'b1
  } asp_rx_state_t;

endpackage

// ==== include/asp_link_if.sv ====
// Serial line pair between the port and the remote transceiver
`timescale 1ns/1ps
`default_nettype none
interface asp_link_if;
  logic serial_out_pin;  // Port transmit line, idles high
  logic serial_in_pin;   // Port receive line, idles high

  modport dev (output serial_out_pin, input serial_in_pin);
  modport rmt (input serial_out_pin, output serial_in_pin);
endinterface
`default_nettype wire

// ==== rtl/asp_port.sv ====
// Serial port unit: control register, data buffer, transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
module asp_port (
  input  wire logic       CLK,         // System clock, 25 MHz
  input  wire logic       RST_N,       // Asynchronous reset, active low
  input  wire logic [7:0] SFR_ADDR,    // Register address
  input  wire logic       SFR_WR,      // Write strobe, one cycle
  input  wire logic [7:0] SFR_WDATA,   // Write data
  output logic      [7:0] SFR_RDATA,   // Read data, one cycle after address
  input  wire logic       TMR_TICK,    // Baud timer count pulse
  input  wire logic       TMR_RUN,     // Baud timer enable
  input  wire logic [7:0] TMR_RELOAD,  // Baud timer reload value
  input  wire logic       IRQ_ENABLE,  // Port interrupt enable
  output logic            IRQ,         // Interrupt request, level
  asp_link_if.dev         link         // Serial lines
);

  typedef struct packed {
    logic [7:0]             ctrl;
    logic [7:0]             rx_buf;
    logic [7:0]             rdata;
    logic [7:0]             tx_tmr;
    logic                   tx_half;
    logic [10:0]            tx_shift;
    logic [3:0]             tx_left;
    logic                   tx_line;
    logic [7:0]             rx_tmr;
    logic                   rx_half;
    asp_pkg::asp_rx_state_t rx_state;
    logic [3:0]             rx_idx;
    logic [8:0]             rx_bits;
    logic                   rx_prev;
  } asp_dev_state_t;

  asp_dev_state_t s;
  asp_dev_state_t next_s;

  logic tick;
  logic tx_ovf;
  logic rx_ovf;
  logic tx_bit;
  logic rx_sample;
  logic line_in;
  logic mode9;
  logic ninth;
  logic load_ok;
  logic wr_ctrl;
  logic wr_data;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_s    = s;
    line_in   = link.serial_in_pin;
    mode9     = s.ctrl[asp_pkg::BIT_MODE];
    tick      = TMR_RUN && TMR_TICK;
    tx_ovf    = tick && (s.tx_tmr == asp_pkg::TIMER_TOP);
    rx_ovf    = tick && (s.rx_tmr == asp_pkg::TIMER_TOP);
    tx_bit    = tx_ovf && s.tx_half;
    rx_sample = rx_ovf && !s.rx_half;
    wr_ctrl   = SFR_WR && (SFR_ADDR == asp_pkg::ADDR_CTRL);
    wr_data   = SFR_WR && (SFR_ADDR == asp_pkg::ADDR_DATA);
    ninth     = 1'b0;
    load_ok   = 1'b0;
    next_s.rx_prev = line_in;

    // Two reload timers; receive copy shares the reload value and restarts on a start edge
    if (tick)
    begin
      next_s.tx_tmr = tx_ovf ? TMR_RELOAD : s.tx_tmr + 8'h01;
      next_s.rx_tmr = rx_ovf ? TMR_RELOAD : s.rx_tmr + 8'h01;
    end
    if (tx_ovf)
    begin
      next_s.tx_half = !s.tx_half;
    end
    if (rx_ovf)
    begin
      next_s.rx_half = !s.rx_half;
    end

    // Software write first, so hardware sets below win over clears
    if (wr_ctrl)
    begin
      next_s.ctrl = SFR_WDATA | asp_pkg::UNUSED_MASK;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter: waits for the next bit boundary of its own timer
    if (wr_data)
    begin
      next_s.tx_shift = mode9
        ? {1'b1, s.ctrl[asp_pkg::BIT_TB8], SFR_WDATA, 1'b0}
        : {1'b1, 1'b1, SFR_WDATA, 1'b0};
      next_s.tx_left  = mode9 ? asp_pkg::FRAME9_BITS : asp_pkg::FRAME8_BITS;
    end
    else if (tx_bit && (s.tx_left != 4'h0))
    begin
      next_s.tx_line  = s.tx_shift[0];
      next_s.tx_shift = {1'b1, s.tx_shift[10:1]};
      next_s.tx_left  = s.tx_left - 4'h1;
      if (s.tx_left == 4'h1)
      begin
        next_s.ctrl[asp_pkg::BIT_TI] = 1'b1;
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver
    unique case (s.rx_state)
      asp_pkg::RX_IDLE:
      begin
        if (s.ctrl[asp_pkg::BIT_REN] && s.rx_prev && !line_in)
        begin
          next_s.rx_state = asp_pkg::RX_BITS;
          next_s.rx_idx   = 4'h0;
          next_s.rx_tmr   = TMR_RELOAD;
          next_s.rx_half  = 1'b0;
        end
      end
      asp_pkg::RX_BITS:
      begin
        if (rx_sample)
        begin
          // First overflow after the edge lands mid start bit
          if ((s.rx_idx == 4'h0) && line_in)
          begin
            next_s.rx_state = asp_pkg::RX_IDLE;
          end
          else if (s.rx_idx == (mode9 ? asp_pkg::LAST9_IDX : asp_pkg::LAST8_IDX))
          begin
            next_s.rx_state = asp_pkg::RX_IDLE;
            ninth   = mode9 ? s.rx_bits[8] : line_in;
            load_ok = !s.ctrl[asp_pkg::BIT_RI]
                      && (!s.ctrl[asp_pkg::BIT_CHECK] || ninth);
            if (load_ok)
            begin
              next_s.rx_buf                 = s.rx_bits[7:0];
              next_s.ctrl[asp_pkg::BIT_RB8] = ninth;
              next_s.ctrl[asp_pkg::BIT_RI]  = 1'b1;
            end
          end
          else
          begin
            // Index zero is the start bit, which is not stored
            if (s.rx_idx != 4'h0)
            begin
              next_s.rx_bits[s.rx_idx - 4'h1] = line_in;
            end
            next_s.rx_idx = s.rx_idx + 4'h1;
          end
        end
      end
    endcase

    // Read path: transmit register is never readable
    if (SFR_ADDR == asp_pkg::ADDR_CTRL)
    begin
      next_s.rdata = s.ctrl | asp_pkg::UNUSED_MASK;
    end
    else if (SFR_ADDR == asp_pkg::ADDR_DATA)
    begin
      next_s.rdata = s.rx_buf;
    end
    else
    begin
      next_s.rdata = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s          <= '0;
      s.ctrl     <= asp_pkg::CTRL_RESET;
      s.rx_buf   <= asp_pkg::DATA_RESET;
      s.tx_line  <= 1'b1;
      s.tx_shift <= '1;
      s.rx_prev  <= 1'b1;
      s.rx_state <= asp_pkg::RX_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign SFR_RDATA           = s.rdata;
  assign link.serial_out_pin = s.tx_line;
  assign IRQ = IRQ_ENABLE && (s.ctrl[asp_pkg::BIT_TI] || s.ctrl[asp_pkg::BIT_RI]);

endmodule
`default_nettype wire

// ==== rtl/asp_remote.sv ====
// Remote transceiver end, programmed over APB
`timescale 1ns/1ps
`default_nettype none
module asp_remote (
  input  wire logic        CLK,      // System clock, 25 MHz
  input  wire logic        RST_N,    // Asynchronous reset, active low
  input  wire logic        PSEL,     // APB select
  input  wire logic        PENABLE,  // APB access phase
  input  wire logic        PWRITE,   // APB direction
  input  wire logic [7:0]  PADDR,    // APB byte address
  input  wire logic [31:0] PWDATA,   // APB write data
  output logic      [31:0] PRDATA,   // APB read data, registered
  output logic             PREADY,   // APB ready, low on a transmit data write while transmitter busy
  output logic             PSLVERR,  // APB error on unmapped address
  asp_link_if.rmt          link      // Serial lines
);

  typedef struct packed {
    logic                   nine;
    logic [15:0]            div;
    logic [10:0]            tx_shift;
    logic [3:0]             tx_left;
    logic [15:0]            tx_cnt;
    logic                   tx_line;
    asp_pkg::asp_rx_state_t rx_state;
    logic [15:0]            rx_cnt;
    logic [3:0]             rx_idx;
    logic [8:0]             rx_bits;
    logic [9:0]             rx_data;
    logic                   rx_valid;
    logic                   rx_over;
    logic                   rx_prev;
    logic [31:0]            prdata;
  } asp_rmt_state_t;

  asp_rmt_state_t s;
  asp_rmt_state_t next_s;

  logic line_in;
  logic mapped;
  logic access;
  logic done;

  always_comb
  begin
    mapped = (PADDR == asp_pkg::RMT_CTRL) || (PADDR == asp_pkg::RMT_DIV)
             || (PADDR == asp_pkg::RMT_TXDATA) || (PADDR == asp_pkg::RMT_RXDATA)
             || (PADDR == asp_pkg::RMT_STATUS);
    access = PSEL && PENABLE;
    // Stalling the write keeps the line from being cut mid frame
    PREADY = !(PWRITE && (PADDR == asp_pkg::RMT_TXDATA) && (s.tx_left != 4'h0));
    PSLVERR = access && !mapped;
    done = access && PREADY;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_s  = s;
    line_in = link.serial_out_pin;
    next_s.rx_prev = line_in;

    if (PSEL && !PENABLE && !PWRITE)
    begin
      unique case (PADDR)
        asp_pkg::RMT_CTRL:   next_s.prdata = {31'h0, s.nine};
        asp_pkg::RMT_DIV:    next_s.prdata = {16'h0, s.div};
        asp_pkg::RMT_RXDATA: next_s.prdata = {22'h0, s.rx_data};
        asp_pkg::RMT_STATUS:
          next_s.prdata = {29'h0, s.rx_over, s.rx_valid, (s.tx_left != 4'h0)};
        default:             next_s.prdata = 32'h0;
      endcase
    end

    if (done && !PWRITE && (PADDR == asp_pkg::RMT_RXDATA))
    begin
      next_s.rx_valid = 1'b0;
      next_s.rx_over  = 1'b0;
    end
    if (done && PWRITE)
    begin
      unique case (PADDR)
        asp_pkg::RMT_CTRL: next_s.nine = PWDATA[0];
        asp_pkg::RMT_DIV:  next_s.div  = PWDATA[15:0];
        asp_pkg::RMT_TXDATA:
        begin
          // Ninth bit from software: one marks an address, zero data
          next_s.tx_shift = s.nine ? {1'b1, PWDATA[8], PWDATA[7:0], 1'b0}
                                   : {1'b1, 1'b1, PWDATA[7:0], 1'b0};
          // One extra step holds the stop bit for its whole time
          next_s.tx_left  = (s.nine ? asp_pkg::FRAME9_BITS : asp_pkg::FRAME8_BITS) + 4'h1;
          next_s.tx_cnt   = 16'h0;
        end
        default: next_s.nine = s.nine;
      endcase
    end
    else if (s.tx_left != 4'h0)
    begin
      if (s.tx_cnt == 16'h0)
      begin
        next_s.tx_line  = s.tx_shift[0];
        next_s.tx_shift = {1'b1, s.tx_shift[10:1]};
        next_s.tx_left  = s.tx_left - 4'h1;
        next_s.tx_cnt   = s.div - 16'h1;
      end
      else
      begin
        next_s.tx_cnt = s.tx_cnt - 16'h1;
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    unique case (s.rx_state)
      asp_pkg::RX_IDLE:
      begin
        if (s.rx_prev && !line_in)
        begin
          next_s.rx_state = asp_pkg::RX_BITS;
          next_s.rx_idx   = 4'h0;
          next_s.rx_cnt   = {1'b0, s.div[15:1]};
        end
      end
      asp_pkg::RX_BITS:
      begin
        if (s.rx_cnt != 16'h0)
        begin
          next_s.rx_cnt = s.rx_cnt - 16'h1;
        end
        else
        begin
          next_s.rx_cnt = s.div - 16'h1;
          if ((s.rx_idx == 4'h0) && line_in)
          begin
            next_s.rx_state = asp_pkg::RX_IDLE;
          end
          else if (s.rx_idx == (s.nine ? asp_pkg::LAST9_IDX : asp_pkg::LAST8_IDX))
          begin
            next_s.rx_state = asp_pkg::RX_IDLE;
            next_s.rx_data  = {line_in, (s.nine ? s.rx_bits[8] : line_in), s.rx_bits[7:0]};
            next_s.rx_over  = s.rx_valid && !(done && !PWRITE
                                              && (PADDR == asp_pkg::RMT_RXDATA));
            next_s.rx_valid = 1'b1;
          end
          else
          begin
            // Index zero is the start bit, which is not stored
            if (s.rx_idx != 4'h0)
            begin
              next_s.rx_bits[s.rx_idx - 4'h1] = line_in;
            end
            next_s.rx_idx = s.rx_idx + 4'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s          <= '0;
      s.div      <= asp_pkg::RMT_DIV_RESET;
      s.tx_line  <= 1'b1;
      s.tx_shift <= '1;
      s.rx_prev  <= 1'b1;
      s.rx_state <= asp_pkg::RX_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign PRDATA             = s.prdata;
  assign link.serial_in_pin = s.tx_line;

endmodule
`default_nettype wire

// ==== test/asp_link_checker.sv ====
// Assertions on the serial link and the port's register outputs
`timescale 1ns/1ps
`default_nettype none
module asp_link_checker (
  input wire logic       CLK,             // System clock
  input wire logic       RST_N,           // Reset, active low
  input wire logic       serial_out_pin,  // Port transmit line
  input wire logic       serial_in_pin,   // Port receive line
  input wire logic [7:0] SFR_ADDR,        // Port register address
  input wire logic       SFR_WR,          // Port write strobe
  input wire logic [7:0] SFR_RDATA,       // Port read data
  input wire logic       IRQ_ENABLE,      // Interrupt enable
  input wire logic       IRQ              // Interrupt request
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_out_idle_reset: assert property ($rose(RST_N) |-> serial_out_pin)
    else $error("transmit line low after reset");
  a_in_idle_reset: assert property ($rose(RST_N) |-> serial_in_pin)
    else $error("receive line low after reset");
  // Bit time is 16 cycles here, so any level lasts at least 9
  a_out_bit_hold: assert property ($changed(serial_out_pin) |=> $stable(serial_out_pin) [*8])
    else $error("transmit bit shorter than a bit time");
  a_in_bit_hold: assert property ($changed(serial_in_pin) |=> $stable(serial_in_pin) [*8])
    else $error("receive bit shorter than a bit time");
  a_irq_masked: assert property (!IRQ_ENABLE |-> !IRQ)
    else $error("interrupt while disabled");
  a_irq_sw_clear: assert property ($fell(IRQ) |-> $past(SFR_WR) || $fell(IRQ_ENABLE))
    else $error("flag cleared without a write");
  a_ctrl_bit6: assert property ($past(RST_N) && $past(SFR_ADDR) == asp_pkg::ADDR_CTRL
    |-> SFR_RDATA[6])
    else $error("control bit 6 read as zero");
  a_unmapped_zero: assert property ($past(RST_N) && $past(SFR_ADDR) != asp_pkg::ADDR_CTRL
    && $past(SFR_ADDR) != asp_pkg::ADDR_DATA |-> SFR_RDATA == 8'h00)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ==== test/async_serial_port_modes_test.sv ====
// Bench joining the serial port and the remote transceiver
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_modes_test;
  logic        clk;
  logic        rst_n;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        irq_en;
  logic        irq;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  ctl;
  int          fail_count;
  int          cmp_count;

  asp_link_if link ();
  // Timer ticks every cycle, reload 0xF8: 16 cycles a bit, same as the remote divider
  asp_port i_asp_port (.CLK(clk), .RST_N(rst_n), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr),
    .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .TMR_TICK(1'b1), .TMR_RUN(1'b1),
    .TMR_RELOAD(8'hF8), .IRQ_ENABLE(irq_en), .IRQ(irq), .link(link.dev));
  asp_remote i_asp_remote (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .link(link.rmt));
  asp_link_checker i_asp_link_checker (.CLK(clk), .RST_N(rst_n),
    .serial_out_pin(link.serial_out_pin), .serial_in_pin(link.serial_in_pin),
    .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr), .SFR_RDATA(sfr_rdata), .IRQ_ENABLE(irq_en),
    .IRQ(irq));

  always #20 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr_addr <= a;
    @(posedge clk);
    @(negedge clk);
    check({24'h0, sfr_rdata}, {24'h0, exp});
  endtask

  task automatic ctrl_set(input logic [7:0] v);
    ctl = v;
    sfr_write(asp_pkg::ADDR_CTRL, v);
  endtask

  // Request held until pready is seen high with psel and penable
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic poll(input int b, input logic v);
    for (int i = 0; i < 150; i++)
    begin
      apb(1'b0, asp_pkg::RMT_STATUS, 32'h0);
      if (rd[b] === v)
        break;
    end
    // A status bit that never settles counts as a mismatch
    check({31'h0, rd[b]}, {31'h0, v});
  endtask

  task automatic rsend(input logic [8:0] d);
    apb(1'b1, asp_pkg::RMT_TXDATA, {23'h0, d});
    poll(0, 1'b0);
  endtask

  // Port sends a byte; flag must rise exactly as the stop bit begins
  task automatic dtx(input logic [7:0] d, input logic m9);
    logic prev;
    sfr_write(asp_pkg::ADDR_DATA, d);
    prev = 1'b1;
    for (int i = 0; i < 600 && irq !== 1'b1; i++)
    begin
      prev = link.serial_out_pin;
      @(posedge clk);
    end
    check({31'h0, prev}, {31'h0, m9 ? ctl[3] : d[7]});
    check({31'h0, link.serial_out_pin}, 32'h1);
    poll(1, 1'b1);
    apb(1'b0, asp_pkg::RMT_RXDATA, 32'h0);
    check({23'h0, rd[9], rd[7:0]}, {23'h0, 1'b1, d});
    if (m9)
      check({31'h0, rd[8]}, {31'h0, ctl[3]});
    rdchk(asp_pkg::ADDR_CTRL, ctl | 8'h42);
    ctrl_set(ctl);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdchk(asp_pkg::ADDR_CTRL, 8'h40);
    rdchk(asp_pkg::ADDR_DATA, 8'h00);
    rdchk(8'h97, 8'h00);
    ctrl_set(8'h00);
    rdchk(asp_pkg::ADDR_CTRL, 8'h40);
    apb(1'b0, 8'h14, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_tx();
    irq_en <= 1'b1;
    ctrl_set(8'h00);
    dtx(8'h35, 1'b0);
    apb(1'b1, asp_pkg::RMT_CTRL, 32'h1);
    ctrl_set(8'h88);
    dtx(8'hC3, 1'b1);
    ctrl_set(8'h80);
    dtx(8'h5A, 1'b1);
    $display("t_tx done");
  endtask

  task automatic t_rx8();
    apb(1'b1, asp_pkg::RMT_CTRL, 32'h0);
    ctrl_set(8'h00);
    rsend(9'h0A5);
    rdchk(asp_pkg::ADDR_CTRL, 8'h40);
    ctrl_set(8'h30);
    rsend(9'h05A);
    rdchk(asp_pkg::ADDR_DATA, 8'h5A);
    rdchk(asp_pkg::ADDR_CTRL, 8'h75);
    check({31'h0, irq}, 32'h1);
    rsend(9'h011);
    rdchk(asp_pkg::ADDR_DATA, 8'h5A);
    rdchk(asp_pkg::ADDR_CTRL, 8'h75);
    $display("t_rx8 done");
  endtask

  task automatic t_rx9();
    apb(1'b1, asp_pkg::RMT_CTRL, 32'h1);
    ctrl_set(8'hB0);
    rsend(9'h022);
    rdchk(asp_pkg::ADDR_CTRL, 8'hF0);
    rsend(9'h133);
    rdchk(asp_pkg::ADDR_DATA, 8'h33);
    rdchk(asp_pkg::ADDR_CTRL, 8'hF5);
    ctrl_set(8'h90);
    rsend(9'h044);
    rdchk(asp_pkg::ADDR_DATA, 8'h44);
    rdchk(asp_pkg::ADDR_CTRL, 8'hD1);
    // Flag still set: masking must drop the request at once
    @(posedge clk);
    irq_en <= 1'b0;
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    $display("t_rx9 done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (30000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    irq_en = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ctl = 8'h00;
    fail_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_tx();
    t_rx8();
    t_rx9();
    summarize();
  end
endmodule
`default_nettype wire
